//--- include/pba_pkg.sv
// constants and carrier types for the power versus background arbiter
package pba_pkg;
   // register byte offsets
   localparam logic [7:0] PBA_CTRL_OFS = 8'h00;
   localparam logic [7:0] PBA_STAT_OFS = 8'h04;
   // control field positions
   localparam int PBA_PRIO_POS = 0;
   localparam int PBA_IDLE_POS = 2;
   localparam int PBA_STBY_POS = 4;
   localparam int PBA_STOP_POS = 6;
   localparam int PBA_BGEN_POS = 8;
   localparam int PBA_MAX_BG = 8;
   // control reset: bg first, idle/standby report off, stopped report on, both bg enabled
   localparam logic [15:0] PBA_CTRL_RST = 16'h0380;
   // two-bit codes
   localparam logic [1:0] PBA_PRIO_ZERO = 2'h0;
   localparam logic [1:0] PBA_PRIO_BG = 2'h1;
   localparam logic [1:0] PBA_PRIO_LP = 2'h2;
   localparam logic [1:0] PBA_RPT_ON = 2'h2;
   // status field positions
   localparam int PBA_ST_COND_POS = 0;
   localparam int PBA_ST_EXP_POS = 3;
   localparam int PBA_ST_TMR_POS = 8;
   localparam int PBA_ST_RUN_POS = 9;
   localparam int PBA_ST_PEND_POS = 12;
   // power condition codes; expired timer bit i maps to condition i+1
   localparam int PBA_NTMR = 5;
   localparam logic [2:0] PBA_PC_ACTIVE = 3'h0;
   localparam logic [2:0] PBA_PC_IDLE_A = 3'h1;
   localparam logic [2:0] PBA_PC_IDLE_C = 3'h3;
   localparam logic [2:0] PBA_PC_STBY_Y = 3'h4;
   localparam logic [2:0] PBA_PC_STBY_Z = 3'h5;
   localparam logic [2:0] PBA_PC_STOPPED = 3'h6;
   // exit source codes on the report output
   localparam logic [1:0] PBA_SRC_IDLE = 2'h1;
   localparam logic [1:0] PBA_SRC_STBY = 2'h2;
   localparam logic [1:0] PBA_SRC_STOP = 2'h3;

   typedef enum logic [1:0] {PBA_ST_ACTIVE, PBA_ST_LOW, PBA_ST_BG} pba_state_t;

   // classic wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pba_wb_req_t;

   // host side event bundle
   typedef struct packed {
      logic cmd;
      logic stop;
      logic busy;
   } pba_host_t;
endpackage : pba_pkg

//--- src/pba_sched.sv
// pending background function tracker with fixed lowest-index pick
`timescale 1ns/1ps
`default_nettype none
module pba_sched #(
   parameter int NBG = 2,
   parameter int IW = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [NBG-1:0] trig_i,
   input wire logic [NBG-1:0] en_i,
   input wire logic clr_i,
   input wire logic [IW-1:0] clr_idx_i,
   output logic [NBG-1:0] pend_o,
   output logic any_o,
   output logic [IW-1:0] idx_o
);
   import pba_pkg::*;

   typedef struct packed {
      logic [NBG-1:0] pend;
   } pba_sched_st_t;

   pba_sched_st_t st;
   pba_sched_st_t next_st;

   ////////////////////////////////////////////////////////////////////////
   // per function pending bit; a new trigger beats a same-cycle clear
   genvar g;
   generate
      for (g = 0; g < NBG; g++) begin : g_pend
         always_comb begin
            next_st.pend[g] = st.pend[g];
            if (clr_i && clr_idx_i == IW'(g)) begin
               next_st.pend[g] = 1'b0;
            end
            if (trig_i[g] && en_i[g]) begin
               next_st.pend[g] = 1'b1;
            end
         end
         pend_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
            st.pend[g] && !(clr_i && clr_idx_i == IW'(g)) |=> st.pend[g])
            else $error("pending background function lost");
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      any_o = |st.pend;
      idx_o = '0;
      for (int i = NBG - 1; i >= 0; i--) begin
         if (st.pend[i]) begin
            idx_o = IW'(i);
         end
      end
   end
   assign pend_o = st.pend;
endmodule : pba_sched
`default_nettype wire

//--- src/pba_arbiter.sv
// power condition versus background function arbiter with wishbone registers
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - idle exit report: 10b enables it, 01b disables, 00b/11b never report
// - standby exit report: 10b enables it, 01b disables, others never report
// - stopped exit report: 10b enables it, 01b disables, others never report
// - priority code zero behaves exactly as background-first
// - background-first: leave timer-entered low power when an enabled trigger is pending
// - background-first: host command suspends running function and is serviced
// - every enabled triggered function runs; lowest index first
// - after last function, enter highest expired timer condition
// - background-first: timer expiry waits until all functions finish
// - low-power-first: never leave low power for a background function
// - low-power-first: expiry during a function suspends it, enters that condition
// - low-power-first: run only when active by host and no host work outstanding
module pba_arbiter #(
   parameter int NBG = 2
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pba_pkg::pba_wb_req_t wb_req_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pba_pkg::pba_host_t host_i,
   input wire logic [pba_pkg::PBA_NTMR-1:0] timer_expired_i,
   input wire logic [NBG-1:0] bg_trigger_i,
   input wire logic bg_done_i,
   output logic [2:0] power_cond_o,
   output logic bg_run_o,
   output logic [((NBG > 1) ? $clog2(NBG) : 1)-1:0] bg_id_o,
   output logic check_cond_o,
   output logic [1:0] check_src_o
);
   import pba_pkg::*;

   localparam int IW = (NBG > 1) ? $clog2(NBG) : 1;

   typedef struct packed {
      pba_state_t state;
      logic [2:0] cond;
      logic [PBA_NTMR-1:0] exp;
      logic from_timer;
      logic run;
      logic [IW-1:0] id;
      logic [15:0] ctrl;
      logic ack;
      logic [31:0] rdat;
      logic chk;
      logic [1:0] src;
   } pba_st_t;

   pba_st_t st;
   pba_st_t next_st;
   logic [NBG-1:0] pend;
   logic bg_any;
   logic [IW-1:0] bg_pick;
   logic clr;
   logic bg_first;
   logic [1:0] prio;
   logic [1:0] rpt_idle;
   logic [1:0] rpt_stby;
   logic [1:0] rpt_stop;
   logic [PBA_NTMR-1:0] exp_all;
   logic [2:0] deepest;
   logic wb_hit;

   ////////////////////////////////////////////////////////////////////////
   // live settings decode; a write lands in the register one edge before use
   assign prio = st.ctrl[PBA_PRIO_POS +: 2];
   assign rpt_idle = st.ctrl[PBA_IDLE_POS +: 2];
   assign rpt_stby = st.ctrl[PBA_STBY_POS +: 2];
   assign rpt_stop = st.ctrl[PBA_STOP_POS +: 2];
   // zero code and reserved code fold to background-first
   assign bg_first = (prio != PBA_PRIO_LP);
   assign exp_all = st.exp | timer_expired_i;
   assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !st.ack;

   // highest expired timer wins: deeper condition has higher priority
   always_comb begin
      deepest = PBA_PC_ACTIVE;
      for (int i = 0; i < PBA_NTMR; i++) begin
         if (exp_all[i]) begin
            deepest = 3'(i + 1);
         end
      end
   end

   pba_sched #(
      .NBG(NBG),
      .IW(IW)
   ) u_sched (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .trig_i(bg_trigger_i),
      .en_i(st.ctrl[PBA_BGEN_POS +: NBG]),
      .clr_i(clr),
      .clr_idx_i(st.id),
      .pend_o(pend),
      .any_o(bg_any),
      .idx_o(bg_pick)
   );
   // a function leaves the pending set only when it reports done
   assign clr = (st.state == PBA_ST_BG) && bg_done_i;

   ////////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      next_st = st;
      next_st.chk = 1'b0;
      next_st.exp = exp_all;
      // host activity restarts every inactivity timer
      if (host_i.cmd) begin
         next_st.exp = '0;
      end
      unique case (st.state)
         PBA_ST_ACTIVE: begin
            if (host_i.stop) begin
               next_st.state = PBA_ST_LOW;
               next_st.cond = PBA_PC_STOPPED;
               next_st.from_timer = 1'b0;
            // host work done before any function
            end else if (bg_any && !host_i.cmd && !host_i.busy) begin
               next_st.state = PBA_ST_BG;
               next_st.run = 1'b1;
               next_st.id = bg_pick;
            end else if (deepest != PBA_PC_ACTIVE && !host_i.cmd && !host_i.busy) begin
               next_st.state = PBA_ST_LOW;
               next_st.cond = deepest;
               next_st.from_timer = 1'b1;
               next_st.exp = '0;
            end
         end
         PBA_ST_LOW: begin
            if (host_i.cmd) begin
               // exit for a command; report per source class
               next_st.state = PBA_ST_ACTIVE;
               next_st.cond = PBA_PC_ACTIVE;
               next_st.from_timer = 1'b0;
               if (st.cond == PBA_PC_STOPPED) begin
                  next_st.chk = (rpt_stop == PBA_RPT_ON);
                  next_st.src = PBA_SRC_STOP;
               end else if (st.cond >= PBA_PC_STBY_Y) begin
                  next_st.chk = (rpt_stby == PBA_RPT_ON);
                  next_st.src = PBA_SRC_STBY;
               end else begin
                  next_st.chk = (rpt_idle == PBA_RPT_ON);
                  next_st.src = PBA_SRC_IDLE;
               end
            // leave timer-entered condition for a pending function
            end else if (bg_first && st.from_timer && bg_any) begin
               next_st.state = PBA_ST_BG;
               next_st.cond = PBA_PC_ACTIVE;
               next_st.from_timer = 1'b0;
               next_st.run = 1'b1;
               next_st.id = bg_pick;
            // low-power-first stays put; deeper timers still apply
            end else if (st.from_timer && deepest > st.cond) begin
               next_st.cond = deepest;
               next_st.exp = '0;
            end
         end
         PBA_ST_BG: begin
            if (host_i.stop) begin
               // a stop is serviced at once; going via active would lose the one-cycle pulse
               next_st.state = PBA_ST_LOW;
               next_st.run = 1'b0;
               next_st.cond = PBA_PC_STOPPED;
               next_st.from_timer = 1'b0;
            end else if (host_i.cmd) begin
               // suspend for the host, function stays pending
               next_st.state = PBA_ST_ACTIVE;
               next_st.run = 1'b0;
            end else if (!bg_first && deepest != PBA_PC_ACTIVE) begin
               next_st.state = PBA_ST_LOW;
               next_st.run = 1'b0;
               next_st.cond = deepest;
               next_st.from_timer = 1'b1;
               next_st.exp = '0;
            end else if (bg_done_i) begin
               // chain to the next pending function
               if ((pend & ~(NBG'(1) << st.id)) != '0) begin
                  next_st.state = PBA_ST_ACTIVE;
                  next_st.run = 1'b0;
               end else if (deepest != PBA_PC_ACTIVE) begin
                  next_st.state = PBA_ST_LOW;
                  next_st.run = 1'b0;
                  next_st.cond = deepest;
                  next_st.from_timer = 1'b1;
                  next_st.exp = '0;
               end else begin
                  next_st.state = PBA_ST_ACTIVE;
                  next_st.run = 1'b0;
               end
            end
            // otherwise expiry stays latched until done
         end
      endcase

      // wishbone slave: ack one cycle after request, unmapped reads zero
      next_st.ack = wb_hit;
      next_st.rdat = '0;
      if (wb_hit && !wb_req_i.we && wb_req_i.adr == PBA_CTRL_OFS) begin
         next_st.rdat = {16'h0000, st.ctrl};
      end else if (wb_hit && !wb_req_i.we && wb_req_i.adr == PBA_STAT_OFS) begin
         next_st.rdat[PBA_ST_COND_POS +: 3] = st.cond;
         next_st.rdat[PBA_ST_EXP_POS +: PBA_NTMR] = st.exp;
         next_st.rdat[PBA_ST_TMR_POS] = st.from_timer;
         next_st.rdat[PBA_ST_RUN_POS] = st.run;
         next_st.rdat[PBA_ST_PEND_POS +: NBG] = pend;
      end
      if (wb_hit && wb_req_i.we && wb_req_i.adr == PBA_CTRL_OFS) begin
         if (wb_req_i.sel[0]) begin
            next_st.ctrl[7:0] = wb_req_i.dat[7:0];
         end
         if (wb_req_i.sel[1]) begin
            next_st.ctrl[15:8] = wb_req_i.dat[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // single state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
         st.ctrl <= PBA_CTRL_RST;
      end else begin
         st <= next_st;
      end
   end

   assign wb_dat_o = st.rdat;
   assign wb_ack_o = st.ack;
   assign power_cond_o = st.cond;
   assign bg_run_o = st.run;
   assign bg_id_o = st.id;
   assign check_cond_o = st.chk;
   assign check_src_o = st.src;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   idle_report_a: assert property (
      st.state == PBA_ST_LOW && st.cond >= PBA_PC_IDLE_A && st.cond <= PBA_PC_IDLE_C && host_i.cmd
      |=> check_cond_o == ($past(rpt_idle) == PBA_RPT_ON) && check_src_o == PBA_SRC_IDLE)
      else $error("idle exit report wrong");

   standby_report_a: assert property (
      st.state == PBA_ST_LOW && (st.cond == PBA_PC_STBY_Y || st.cond == PBA_PC_STBY_Z) && host_i.cmd
      |=> check_cond_o == ($past(rpt_stby) == PBA_RPT_ON) ##1 !check_cond_o)
      else $error("standby exit report wrong");

   stopped_report_a: assert property (
      st.state == PBA_ST_LOW && st.cond == PBA_PC_STOPPED && host_i.cmd && rpt_stop != PBA_RPT_ON
      |=> !check_cond_o && power_cond_o == PBA_PC_ACTIVE)
      else $error("stopped exit report wrong");

   bg_exit_low_a: assert property (
      st.state == PBA_ST_LOW && st.from_timer && prio != PBA_PRIO_LP && bg_any && !host_i.cmd
      |=> bg_run_o && power_cond_o == PBA_PC_ACTIVE && bg_id_o == $past(bg_pick))
      else $error("background-first did not leave low power");

   host_suspend_a: assert property (
      st.state == PBA_ST_BG && host_i.cmd |=> !bg_run_o ##1 !bg_run_o || !host_i.busy)
      else $error("function not suspended for host");

   finish_first_a: assert property (
      st.state == PBA_ST_BG && bg_first && !bg_done_i && !host_i.cmd && !host_i.stop
      |=> bg_run_o && power_cond_o == PBA_PC_ACTIVE)
      else $error("timer preempted a background function");

   all_done_a: assert property (
      st.state == PBA_ST_BG && bg_done_i && !host_i.cmd && !host_i.stop && bg_first
      && pend == (NBG'(1) << st.id) && deepest != PBA_PC_ACTIVE
      |=> power_cond_o == $past(deepest) && st.from_timer)
      else $error("expired timer not entered after functions");

   stay_low_a: assert property (
      st.state == PBA_ST_LOW && prio == PBA_PRIO_LP && !host_i.cmd
      |=> st.state == PBA_ST_LOW && !bg_run_o)
      else $error("low-power-first left low power");

   lp_suspend_a: assert property (
      st.state == PBA_ST_BG && prio == PBA_PRIO_LP && !host_i.cmd && !host_i.stop && deepest != PBA_PC_ACTIVE
      |=> !bg_run_o && power_cond_o == $past(deepest))
      else $error("expiry did not suspend function");

   lp_gate_a: assert property (
      st.state == PBA_ST_ACTIVE && (host_i.busy || host_i.cmd) |=> !bg_run_o)
      else $error("function started with host work open");

   ctrl_write_a: assert property (
      wb_hit && wb_req_i.we && wb_req_i.adr == PBA_CTRL_OFS && wb_req_i.sel[0]
      |=> prio == $past(wb_req_i.dat[1:0]) && wb_ack_o)
      else $error("setting write not applied");
endmodule : pba_arbiter
`default_nettype wire

//--- dv/pba_host_model.sv
// host initiator and background worker model facing the arbiter
`timescale 1ns/1ps
`default_nettype none
module pba_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic bg_run_i,
   output var pba_pkg::pba_host_t host_o,
   output logic bg_done_o
);
   import pba_pkg::*;
   int done_lat = 8;
   int run_cnt = 0;
   initial host_o = '0;
   initial bg_done_o = 1'h0;
   //////////////////////////////////////////////////////////////////////////////
   // worker finishes after done_lat cycles; a suspend restarts the count, so a slow
   // worker can be interrupted more than once
   always @(posedge clk_i) begin
      if (rst_i || !bg_run_i || bg_done_o) begin
         run_cnt <= 0;
         bg_done_o <= 1'h0;
      end else begin
         run_cnt <= run_cnt + 1;
         bg_done_o <= (run_cnt + 1 == done_lat);
      end
   end
   //////////////////////////////////////////////////////////////////////////////
   // host commands are one-cycle pulses launched just after an edge
   task send_cmd;
      @(posedge clk_i);
      host_o.cmd <= 1'h1;
      @(posedge clk_i);
      host_o.cmd <= 1'h0;
   endtask : send_cmd
   task send_stop;
      @(posedge clk_i);
      host_o.stop <= 1'h1;
      @(posedge clk_i);
      host_o.stop <= 1'h0;
   endtask : send_stop
   // outstanding host work is a level
   task set_busy(input logic b);
      @(posedge clk_i);
      host_o.busy <= b;
   endtask : set_busy
endmodule : pba_host_model
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the power versus background arbiter
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pba_pkg::*;
   logic clk_i = 1'h0;
   logic rst_i = 1'h1;
   pba_wb_req_t wb_req_i = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   pba_host_t host_i;
   logic [PBA_NTMR-1:0] timer_expired_i = '0;
   logic [1:0] bg_trigger_i = '0;
   logic bg_done_i;
   logic [2:0] power_cond_o;
   logic bg_run_o;
   logic [0:0] bg_id_o;
   logic check_cond_o;
   logic [1:0] check_src_o;
   int n_mismatch = 0;
   int checks = 0;
   logic [1:0] ids_seen = '0;
   logic seen_clr = 1'h0;
   logic [31:0] rd;
   always #2 clk_i = ~clk_i;
   pba_arbiter #(.NBG(2)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .host_i(host_i), .timer_expired_i(timer_expired_i), .bg_trigger_i(bg_trigger_i),
      .bg_done_i(bg_done_i), .power_cond_o(power_cond_o), .bg_run_o(bg_run_o), .bg_id_o(bg_id_o),
      .check_cond_o(check_cond_o), .check_src_o(check_src_o));
   pba_host_model host (.clk_i(clk_i), .rst_i(rst_i), .bg_run_i(bg_run_o), .host_o(host_i),
      .bg_done_o(bg_done_i));
   // remember which functions ever ran; cleared only here so the set has one driver
   always @(posedge clk_i) begin
      if (seen_clr) ids_seen <= '0;
      else if (bg_run_o === 1'h1) ids_seen[bg_id_o] <= 1'h1;
   end
   //////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task close_out;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out
   task do_reset;
      @(posedge clk_i);
      rst_i <= 1'h1;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      @(posedge clk_i);
   endtask : do_reset
   // classic single cycle; held until ack is sampled, a missing ack counts as a mismatch
   task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_req_i <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: 4'hF, dat: dat};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 20);
      rdat = wb_dat_o;
      wb_req_i <= '0;
      if (n >= 20) chk(32'h0, 32'h1);
   endtask : wb
   task set_ctrl(input logic [31:0] v);
      wb(1'h1, PBA_CTRL_OFS, v, rd);
   endtask : set_ctrl
   task pulse(input logic [4:0] t, input logic [1:0] g);
      @(posedge clk_i);
      timer_expired_i <= t;
      bg_trigger_i <= g;
      @(posedge clk_i);
      timer_expired_i <= '0;
      bg_trigger_i <= '0;
   endtask : pulse
   // bounded wait for a condition and run level, then judge both
   task wait_out(input logic [2:0] c, input logic r, input int lim);
      int n;
      n = 0;
      while ((power_cond_o !== c || bg_run_o !== r) && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk(power_cond_o, c);
      chk(bg_run_o, r);
   endtask : wait_out
   task hold(input logic [2:0] c, input logic r, input int n);
      repeat (n) begin
         @(posedge clk_i);
         #1;
         chk({power_cond_o, bg_run_o}, {c, r});
      end
   endtask : hold
   //////////////////////////////////////////////////////////////////////////////
   // settings stored and read back
   task t_regs;
      do_reset();
      wb(1'h0, PBA_CTRL_OFS, 32'h0, rd);
      chk(rd, {16'h0, PBA_CTRL_RST});
      set_ctrl(32'h2A6);
      wb(1'h0, PBA_CTRL_OFS, 32'h0, rd);
      chk(rd, 32'h2A6);
      // function 0 is disabled now: its trigger must be dropped
      pulse(5'h00, 2'h1);
      hold(PBA_PC_ACTIVE, 1'h0, 5);
      wb(1'h1, PBA_STAT_OFS, 32'hFFFF, rd);
      wb(1'h0, PBA_STAT_OFS, 32'h0, rd);
      chk(rd[2:0], PBA_PC_ACTIVE);
      chk(rd[13:12], 2'h0);
      wb(1'h0, 8'h08, 32'h0, rd);
      chk(rd, 32'h0);
   endtask : t_regs
   // every report code for each exit kind
   task t_report;
      logic [2:0] lc;
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < 4; c++) begin
            do_reset();
            set_ctrl(32'h300 | (32'(c) << (PBA_IDLE_POS + 2 * k)));
            lc = (k == 0) ? PBA_PC_IDLE_A : (k == 1) ? PBA_PC_STBY_Y : PBA_PC_STOPPED;
            if (k == 2) host.send_stop();
            else pulse((k == 0) ? 5'h01 : 5'h08, 2'h0);
            wait_out(lc, 1'h0, 10);
            host.send_cmd();
            #1;
            chk(power_cond_o, PBA_PC_ACTIVE);
            chk(check_cond_o, c == 2);
            if (c == 2) chk(check_src_o, k + 1);
            @(posedge clk_i);
            #1;
            chk(check_cond_o, 1'h0);
         end
      end
   endtask : t_report
   // background-first with codes zero, 01b and 11b
   task t_bg_first;
      // codes zero, 01b and the reserved 11b
      for (int p = 0; p < 3; p++) begin
         do_reset();
         set_ctrl(32'h300 | 32'((p == 2) ? 3 : p));
         host.done_lat = 30;
         pulse(5'h01, 2'h0);
         wait_out(PBA_PC_IDLE_A, 1'h0, 10);
         seen_clr = 1'h1;
         @(posedge clk_i);
         #1;
         seen_clr = 1'h0;
         pulse(5'h00, 2'h1);
         wait_out(PBA_PC_ACTIVE, 1'h1, 10);
         pulse(5'h06, 2'h2);
         hold(PBA_PC_ACTIVE, 1'h1, 10);
         wait_out(PBA_PC_IDLE_C, 1'h0, 150);
         hold(PBA_PC_IDLE_C, 1'h0, 5);
         chk(ids_seen, 2'h3);
      end
   endtask : t_bg_first
   // host command suspends a running function
   task t_host_suspend;
      do_reset();
      set_ctrl(32'h301);
      host.done_lat = 200;
      pulse(5'h00, 2'h1);
      wait_out(PBA_PC_ACTIVE, 1'h1, 10);
      host.set_busy(1'h1);
      host.send_cmd();
      wait_out(PBA_PC_ACTIVE, 1'h0, 5);
      hold(PBA_PC_ACTIVE, 1'h0, 8);
      host.set_busy(1'h0);
      wait_out(PBA_PC_ACTIVE, 1'h1, 10);
      wait_out(PBA_PC_ACTIVE, 1'h0, 300);
      // a stop command during a function is serviced, not lost
      pulse(5'h00, 2'h1);
      wait_out(PBA_PC_ACTIVE, 1'h1, 10);
      host.send_stop();
      wait_out(PBA_PC_STOPPED, 1'h0, 5);
      hold(PBA_PC_STOPPED, 1'h0, 5);
   endtask : t_host_suspend
   task t_lp_first;
      do_reset();
      set_ctrl(32'h302);
      host.done_lat = 500;
      pulse(5'h01, 2'h0);
      wait_out(PBA_PC_IDLE_A, 1'h0, 10);
      pulse(5'h00, 2'h1);
      hold(PBA_PC_IDLE_A, 1'h0, 20);
      host.set_busy(1'h1);
      host.send_cmd();
      wait_out(PBA_PC_ACTIVE, 1'h0, 5);
      hold(PBA_PC_ACTIVE, 1'h0, 10);
      host.set_busy(1'h0);
      wait_out(PBA_PC_ACTIVE, 1'h1, 10);
      pulse(5'h08, 2'h0);
      wait_out(PBA_PC_STBY_Y, 1'h0, 5);
   endtask : t_lp_first
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      t_regs();
      t_report();
      t_bg_first();
      t_host_suspend();
      t_lp_first();
      close_out();
   end
   // the tests need about a thousand cycles; this span of 25000 cycles leaves ample margin
   initial begin
      #100000;
      n_mismatch++;
      close_out();
   end
endmodule : tb
`default_nettype wire
